// ### prs_defs.svh
// Constants of the power rail wake-up sequencer: offsets, fields, resets.
// Assumes a byte-addressed 32-bit Wishbone register window.
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// Register byte offsets
`define PRS_CTRL_OFS 8'h00
`define PRS_RAIL_EN_OFS 8'h04
`define PRS_SEQ_SEL_OFS 8'h08
`define PRS_SEQ_GAP_OFS 8'h0C
`define PRS_STATUS_OFS 8'h10

// Field layout
`define PRS_CTRL_SUSP_BIT 0
`define PRS_SEL_W 4
`define PRS_GAP_W 2
`define PRS_STAT_BUSY_BIT 3
`define PRS_STAT_DOWN_BIT 4
`define PRS_STAT_STEP_LSB 8

// Reset values
`define PRS_CTRL_RST 32'h0000_0000
`define PRS_RAIL_EN_RST 8'h00
`define PRS_SEQ_SEL_RST 32'hA987_6543
`define PRS_SEQ_GAP_RST 18'h0_0000

// Sequence shape and timing, times in ms as printed
`define PRS_NUM_STEPS 10
`define PRS_GAP_MIN_MS 2
`define PRS_GAP_MAX_MS 5
`define PRS_WAIT_TIMEOUT_MS 20000
`define PRS_PDOWN_TOTAL_MS 500
`define PRS_CLK_HZ 100000000

`endif

// ### prs_pkg.sv
// Types shared by the power rail wake-up sequencer.
// Assumes prs_defs.svh is compiled alongside.
`default_nettype none

package prs_pkg;
	typedef enum logic [2:0]
	{
		PRS_OFF = 3'b000,
		PRS_PRE_OFF = 3'b001,
		PRS_SUSPEND = 3'b010,
		PRS_WAIT_EN = 3'b011,
		PRS_ACTIVE = 3'b100,
		PRS_PDOWN = 3'b101
	} prs_state_type;
endpackage : prs_pkg

`default_nettype wire

// ### prs_pin_sync.sv
// Two-flop synchroniser with edge detect for a group of pins.
// Assumes pins are asynchronous to ref_clk.
`default_nettype none

module prs_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fall,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	// Pins idle high, so reset to high avoids a false edge at release
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end
		else
		begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign fall = prev_q & ~sync_q;
	assign rise = ~prev_q & sync_q;
endmodule : prs_pin_sync

`default_nettype wire

// ### prs_gap_timer.sv
// Down-counting interval timer: expired pulses loadVal+1 cycles after load.
// Assumes loadVal is at least 1.
`default_nettype none

module prs_gap_timer #(
	parameter int CNT_W = 32
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [CNT_W-1:0] loadVal,
	output logic expired
);
	logic [CNT_W-1:0] cnt_q;
	logic expired_q;
	wire lastTick = (cnt_q == CNT_W'(1)) && !load;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_q <= '0;
			expired_q <= 1'b0;
		end
		else
		begin
			if (load)
				cnt_q <= loadVal;
			else if (cnt_q != '0)
				cnt_q <= cnt_q - CNT_W'(1);
			expired_q <= lastTick;
		end
	end

	assign expired = expired_q;
endmodule : prs_gap_timer

`default_nettype wire

// ### prs_wakeup_sequencer.sv
// Wake-up state machine and ten-step rail power-up/power-down sequencer
// with a classic Wishbone register slave.
// Assumes ref_clk at 100 MHz from the internal oscillator and pins that
// are asynchronous to it.
`default_nettype none
`include "prs_defs.svh"

module prs_wakeup_sequencer
#(
	parameter int NUM_RAILS = 8,
	parameter int CYCLES_PER_MS = `PRS_CLK_HZ / 1000
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic pushbutton_in,
	input wire logic adapter_detect_in,
	input wire logic host_power_enable_in,
	input wire logic undervoltage_lockout,
	input wire logic overtemp_shutdown,
	input wire logic bias_present_in,
	output logic [NUM_RAILS-1:0] rail_enable_o,
	output logic [NUM_RAILS-1:0] rail_discharge_o,
	output logic seq_busy_o,
	output prs_pkg::prs_state_type power_state_o
);
	import prs_pkg::*;

	localparam int SW = `PRS_SEL_W;
	localparam int GW = `PRS_GAP_W;
	localparam int NGAP = `PRS_NUM_STEPS - 1;
	localparam logic [3:0] LAST_STEP = 4'(`PRS_NUM_STEPS - 1);
	localparam logic [31:0] MS_CYC = 32'(CYCLES_PER_MS);
	localparam logic [31:0] WAIT_CYC =
		32'(64'(`PRS_WAIT_TIMEOUT_MS) * 64'(CYCLES_PER_MS));
	localparam logic [31:0] PDOWN_CYC =
		32'(64'(`PRS_PDOWN_TOTAL_MS) * 64'(CYCLES_PER_MS));

	// Synchronised pins: 0 button, 1 adapter, 2 enable, 3 undervoltage_lockout, 4 ots,
	// 5 bias
	logic [5:0] pinLvl;
	logic [5:0] pinFall;
	logic [5:0] pinRise;

	prs_pin_sync #(
		.WIDTH(6)
	) u_pins (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinIn({bias_present_in, overtemp_shutdown, undervoltage_lockout,
			host_power_enable_in, adapter_detect_in, pushbutton_in}),
		.level(pinLvl),
		.fall(pinFall),
		.rise(pinRise)
	);

	wire pbLvl = pinLvl[0];
	wire acLvl = pinLvl[1];
	wire enLvl = pinLvl[2];
	wire fault = pinLvl[3] | pinLvl[4];
	wire pbFall = pinFall[0];
	wire acFall = pinFall[1];
	wire biasRise = pinRise[5];

	// Registers
	logic [31:0] ctrl_q;
	logic [NUM_RAILS-1:0] railEn_q;
	logic [NUM_RAILS-1:0] dischg_q;
	logic [31:0] seqSel_q;
	logic [NGAP*GW-1:0] seqGap_q;

	// State
	prs_state_type state_q;
	prs_state_type state_d;
	prs_state_type pdDest_q;
	prs_state_type pdDest_d;
	logic seqRun_q;
	logic seqDown_q;
	logic [3:0] step_q;
	logic waitExp_q;

	// Wake and power-down decisions
	wire noFault = !fault;
	wire wakeCommon = pbFall | acFall | enLvl;
	wire wakeOff = noFault & (wakeCommon | (biasRise & !acLvl));
	wire wakePreOff = noFault & wakeCommon;
	wire wakeSusp = noFault & (pbFall | acFall | enLvl);
	wire inputsHigh = pbLvl & acLvl;
	wire suspOnRel = ctrl_q[`PRS_CTRL_SUSP_BIT];
	logic startUp;
	logic startDown;
	logic waitExpired;
	logic pdDone;

	always_comb
	begin
		state_d = state_q;
		pdDest_d = pdDest_q;
		startUp = 1'b0;
		startDown = 1'b0;
		unique case (state_q)
			PRS_OFF:
				if (wakeOff)
				begin
					state_d = PRS_WAIT_EN;
					startUp = 1'b1;
				end
			PRS_PRE_OFF:
				if (wakePreOff)
				begin
					state_d = PRS_WAIT_EN;
					startUp = 1'b1;
				end
			PRS_SUSPEND:
				if (wakeSusp)
				begin
					state_d = PRS_WAIT_EN;
					startUp = 1'b1;
				end
			PRS_WAIT_EN:
				if (fault)
				begin
					state_d = PRS_PDOWN;
					pdDest_d = PRS_OFF;
					startDown = 1'b1;
				end
				else if (enLvl)
					state_d = PRS_ACTIVE;
				else if (inputsHigh && waitExp_q)
				begin
					state_d = PRS_PDOWN;
					pdDest_d = PRS_OFF;
					startDown = 1'b1;
				end
				// Otherwise hold while enable low and either an input low or the wait time-out not yet expired
			PRS_ACTIVE:
				// Adapter ignored here, only enable loss or a fault ends the session
				if (fault || !enLvl)
				begin
					state_d = PRS_PDOWN;
					pdDest_d = (!fault && suspOnRel) ? PRS_SUSPEND
						: (fault ? PRS_OFF : PRS_PRE_OFF);
					startDown = 1'b1;
				end
			PRS_PDOWN:
				if (pdDone)
					state_d = pdDest_q;
			default:
				state_d = PRS_OFF;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= PRS_OFF;
			pdDest_q <= PRS_OFF;
		end
		else
		begin
			state_q <= state_d;
			pdDest_q <= pdDest_d;
		end
	end

	// The wait time-out only counts from entry to the wait state
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			waitExp_q <= 1'b0;
		else if (startUp)
			waitExp_q <= 1'b0;
		else if (waitExpired)
			waitExp_q <= 1'b1;
	end

	prs_gap_timer #(
		.CNT_W(32)
	) u_wait_tmr (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.load(startUp),
		.loadVal(WAIT_CYC),
		.expired(waitExpired)
	);

	// Fixed power-down length regardless of programmed gaps
	prs_gap_timer #(
		.CNT_W(32)
	) u_pdown_tmr (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.load(startDown),
		.loadVal(PDOWN_CYC),
		.expired(pdDone)
	);

	// Step engine
	logic gapDone;
	wire gapTick = gapDone & seqRun_q & !startUp & !startDown;
	wire fireNow = startUp | startDown | gapTick;
	wire dirDown = startDown | (!startUp & seqDown_q);
	wire [3:0] fireStep = startUp ? 4'd0
		: startDown ? LAST_STEP
		: (seqDown_q ? step_q - 4'd1 : step_q + 4'd1);
	wire lastFire = dirDown ? (fireStep == 4'd0)
		: (fireStep == LAST_STEP);
	wire [3:0] gapIdx = dirDown ? fireStep - 4'd1 : fireStep;
	wire [GW-1:0] gapCode = seqGap_q[gapIdx*GW +: GW];
	wire [31:0] gapMs = 32'(`PRS_GAP_MIN_MS) + 32'(gapCode);
	wire [31:0] gapCyc = 32'(64'(gapMs) * 64'(MS_CYC));

	prs_gap_timer #(
		.CNT_W(32)
	) u_gap_tmr (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.load(fireNow && !lastFire),
		// Expiry is registered, costing a cycle, so load one short
		.loadVal(gapCyc - 32'd1),
		.expired(gapDone)
	);

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seqRun_q <= 1'b0;
			seqDown_q <= 1'b0;
			step_q <= 4'd0;
		end
		else if (fireNow)
		begin
			seqRun_q <= !lastFire;
			seqDown_q <= dirDown;
			step_q <= fireStep;
		end
	end

	// Wishbone slave: answer one cycle after the request is seen
	logic ack_q;
	logic err_q;
	logic [31:0] rdData_q;
	wire [5:0] regIdx = wb_adr_i[7:2];
	wire hitCtrl = regIdx == 6'(`PRS_CTRL_OFS >> 2);
	wire hitRail = regIdx == 6'(`PRS_RAIL_EN_OFS >> 2);
	wire hitSel = regIdx == 6'(`PRS_SEQ_SEL_OFS >> 2);
	wire hitGap = regIdx == 6'(`PRS_SEQ_GAP_OFS >> 2);
	wire hitStat = regIdx == 6'(`PRS_STATUS_OFS >> 2);
	wire mapped = hitCtrl | hitRail | hitSel | hitGap | hitStat;
	wire newReq = wb_cyc_i & wb_stb_i & !ack_q & !err_q;
	wire refuse = !mapped | (hitRail & seqRun_q);
	wire wrNow = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	wire [31:0] byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] statusWord = {20'h0_0000, 4'(step_q), 3'b000,
		seqDown_q, seqRun_q, 3'(state_q)};
	wire [31:0] railWord = 32'(railEn_q);
	wire [31:0] gapWord = 32'(seqGap_q);
	wire [31:0] rdMux = hitCtrl ? ctrl_q
		: hitRail ? railWord
		: hitSel ? seqSel_q
		: hitGap ? gapWord
		: hitStat ? statusWord
		: 32'h0000_0000;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdData_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= newReq & !refuse;
			err_q <= newReq & refuse;
			if (newReq)
				rdData_q <= refuse ? 32'h0000_0000 : rdMux;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] oldV);
		merge = (oldV & ~byteMask) | (wb_dat_i & byteMask);
	endfunction : merge

	wire [31:0] gapMerged = merge(gapWord);

	// Configuration registers are host-writable at any time
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_q <= `PRS_CTRL_RST;
			seqSel_q <= `PRS_SEQ_SEL_RST;
			seqGap_q <= `PRS_SEQ_GAP_RST;
		end
		else if (wrNow)
		begin
			if (hitCtrl)
				ctrl_q <= merge(ctrl_q) & 32'h0000_0001;
			if (hitSel)
				seqSel_q <= merge(seqSel_q);
			if (hitGap)
				seqGap_q <= gapMerged[NGAP*GW-1:0];
		end
	end

	// Per-rail enable and discharge; a step firing wins over the host
	wire [31:0] hostRail = merge(railWord);
	logic [NUM_RAILS-1:0] railEn_d;
	logic [NUM_RAILS-1:0] dischg_d;

	for (genvar r = 0; r < NUM_RAILS; r++)
	begin : g_rail
		wire [SW-1:0] sel = seqSel_q[r*SW +: SW];
		// Step numbers are 1-based in the select field, zero means none
		wire hit = fireNow && (sel != '0)
			&& (sel == SW'(fireStep) + SW'(1));
		wire hostWr = wrNow && hitRail;
		always_comb
		begin
			railEn_d[r] = railEn_q[r];
			dischg_d[r] = dischg_q[r];
			if (hostWr)
			begin
				railEn_d[r] = hostRail[r];
				dischg_d[r] = dischg_q[r] & !hostRail[r];
			end
			if (hit)
			begin
				railEn_d[r] = !dirDown;
				dischg_d[r] = dirDown;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			railEn_q <= NUM_RAILS'(`PRS_RAIL_EN_RST);
			dischg_q <= '0;
		end
		else
		begin
			railEn_q <= railEn_d;
			dischg_q <= dischg_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdData_q;
	assign rail_enable_o = railEn_q;
	assign rail_discharge_o = dischg_q;
	assign seq_busy_o = seqRun_q;
	assign power_state_o = state_q;
endmodule : prs_wakeup_sequencer

`default_nettype wire

// ### prs_wakeup_sequencer_sva.sv
// Checker for the sequencer's bus, state and rail ports.
// Assumes binding to prs_wakeup_sequencer with one clock domain.
`default_nettype none

module prs_chk #(
	parameter int NUM_RAILS = 8,
	parameter int CYCLES_PER_MS = 10
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic undervoltage_lockout,
	input wire logic [NUM_RAILS-1:0] rail_enable_o,
	input wire logic [NUM_RAILS-1:0] rail_discharge_o,
	input wire logic seq_busy_o,
	input wire prs_pkg::prs_state_type power_state_o
);
	import prs_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire inDown = power_state_o == PRS_PDOWN;
	logic [31:0] downCnt_q;
	// Length of the current power-down stay
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			downCnt_q <= '0;
		else
			downCnt_q <= inDown ? downCnt_q + 1 : '0;
	end
	AST_ANSWER: assert property (busReq |=> wb_ack_o ^ wb_err_o)
		else $error("bus request not answered");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	AST_UNMAPPED: assert property (busReq && wb_adr_i[7:2] > 6'h04
		|=> wb_err_o) else $error("unmapped access accepted");
	AST_RAIL_LOCK: assert property (busReq && wb_adr_i[7:2] == 6'h01
		&& seq_busy_o |=> wb_err_o) else $error("rail word open while busy");
	AST_ERR_DATA: assert property (wb_err_o |-> wb_dat_o == '0)
		else $error("data on refused access");
	AST_WAKE: assert property (power_state_o == PRS_WAIT_EN
		&& $past(power_state_o) inside {PRS_OFF, PRS_PRE_OFF, PRS_SUSPEND}
		|-> seq_busy_o) else $error("wake without sequence");
	AST_LOCKOUT: assert property ((power_state_o == PRS_OFF
		&& undervoltage_lockout) [*4] |=> power_state_o == PRS_OFF)
		else $error("wake under lockout");
	AST_DOWN_NO_RISE: assert property (inDown && seq_busy_o
		|=> (rail_enable_o & ~$past(rail_enable_o)) == '0)
		else $error("rail rose in power-down");
	AST_DISCHARGE: assert property ((rail_enable_o & rail_discharge_o) == '0)
		else $error("discharge on a live rail");
	AST_DOWN_LEN: assert property (!inDown && $past(inDown)
		|-> downCnt_q >= 500 * CYCLES_PER_MS
		&& downCnt_q <= 500 * CYCLES_PER_MS + 1)
		else $error("power-down length wrong");
	COV_WAKE: cover property (power_state_o == PRS_WAIT_EN && seq_busy_o);
	COV_ACTIVE: cover property (power_state_o == PRS_ACTIVE);
	COV_REFUSE: cover property (wb_err_o && seq_busy_o);
endmodule : prs_chk

bind prs_wakeup_sequencer prs_chk #(.NUM_RAILS(NUM_RAILS),
	.CYCLES_PER_MS(CYCLES_PER_MS)) chk (.ref_clk, .reset_n, .wb_cyc_i,
	.wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
	.undervoltage_lockout, .rail_enable_o, .rail_discharge_o, .seq_busy_o,
	.power_state_o);

`default_nettype wire

// ### prs_pin_model.sv
// Button, adapter and host enable pins as seen by the sequencer.
// Assumes bench commands change just after a rising edge.
`default_nettype none

module prs_pin_model (
	input wire logic ref_clk,
	input wire logic pressReq,
	input wire logic hostEnReq,
	input wire logic adapterReq,
	output logic pushbutton_in,
	output logic adapter_detect_in,
	output logic host_power_enable_in
);
	logic [3:0] hold_q = 4'h0;
	initial
	begin
		pushbutton_in = 1'b1;
		adapter_detect_in = 1'b1;
		host_power_enable_in = 1'b0;
	end
	// A press is held a random few cycles, as a hand would
	always @(posedge ref_clk)
	begin
		if (pressReq && hold_q == 4'h0)
			hold_q <= 4'h4 + 4'($urandom % 8);
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
		pushbutton_in <= !(pressReq || hold_q > 4'h1);
		host_power_enable_in <= hostEnReq;
		adapter_detect_in <= !adapterReq;
	end
endmodule : prs_pin_model

`default_nettype wire

// ### test_power_rail_wakeup_sequencer.sv
// Bench for the sequencer: bus tasks, pin model, queued expectations.
// Assumes the design and checker files are compiled first.
`default_nettype none

module test_power_rail_wakeup_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import prs_pkg::*;
	typedef struct {logic rd; logic e; logic [31:0] m; logic [31:0] x;}
		prs_busnote_type;
	typedef struct {logic [7:0] v; int dt;} prs_railnote_type;
	localparam int CPM = 2;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, press = 1'b0;
	logic undervoltage_lockout = 1'b0, hostEn = 1'b0, zero = 1'b0;
	logic adapter = 1'b0, bias = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000, gw;
	logic wb_ack_o, wb_err_o, seq_busy_o;
	logic pushbutton_in, adapter_detect_in, host_power_enable_in;
	logic [31:0] wb_dat_o;
	logic [7:0] rail_enable_o, lastR = 8'h00;
	logic [7:0] dischg;
	prs_state_type power_state_o;
	logic [1:0] gc [9];
	int errors = 0, compares = 0, cycles = 0, n;
	longint lastT = 0;
	prs_busnote_type busQ [$], bn;
	prs_railnote_type railQ [$], rn;

	prs_wakeup_sequencer #(.CYCLES_PER_MS(CPM)) uut (.ref_clk, .reset_n,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pushbutton_in,
		.adapter_detect_in, .host_power_enable_in, .undervoltage_lockout,
		.overtemp_shutdown(zero), .bias_present_in(bias), .rail_enable_o,
		.rail_discharge_o(dischg), .seq_busy_o, .power_state_o);
	prs_pin_model pins (.ref_clk, .pressReq(press), .hostEnReq(hostEn),
		.adapterReq(adapter), .pushbutton_in, .adapter_detect_in,
		.host_power_enable_in);

	always #5 ref_clk = ~ref_clk;

	task automatic check(input string s, input logic [31:0] x,
		input logic [31:0] y);
		compares++;
		if (y !== x)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, x, y);
		end
	endtask : check

	task automatic complete_run();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			complete_run();
		end
	end

	always @(posedge ref_clk)
		if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
		begin
			bn = busQ.pop_front();
			check("bus error", {31'h0, bn.e}, {31'h0, wb_err_o});
			if (bn.rd)
				check("read data", bn.x, wb_dat_o & bn.m);
		end

	// Each rail change is matched with its value, and with its gap in cycles when the note gives one
	always @(posedge ref_clk)
		if (reset_n && rail_enable_o !== lastR)
		begin
			rn = railQ.pop_front();
			check("rails", {24'h0, rn.v}, {24'h0, rail_enable_o});
			if (rn.dt >= 0)
				check("step gap", rn.dt, 32'(($time - lastT) / 10));
			lastT = $time;
			lastR = rail_enable_o;
		end

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic e, input logic [31:0] m);
		busQ.push_back('{!w, e, m, d & m});
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge ref_clk);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic waitFor(input prs_state_type s, input int lim);
		n = 0;
		while (power_state_o !== s && n < lim)
		begin
			@(posedge ref_clk);
			n++;
		end
		check("state", {29'h0, s}, {29'h0, power_state_o});
	endtask : waitFor

	// Rail0 is outside the sequence and must keep its level
	task automatic pushSeq(input logic up);
		logic [7:0] v;
		int t;
		v = up ? 8'h0F : 8'h7F;
		t = 0;
		railQ.push_back('{v, -1});
		for (int i = 0; i < 9; i++)
		begin
			t += (2 + gc[up ? i : 8 - i]) * CPM;
			if (up && i >= 5)
				v[i - 1] = 1'b1;
			if (!up && (i < 3 || i == 8))
				v = (i == 8) ? 8'h01 : v & ~(8'h01 << (6 - i));
			if ((up && i >= 5) || (!up && (i < 3 || i == 8)))
			begin
				railQ.push_back('{v, t});
				t = 0;
			end
		end
	endtask : pushSeq

	task automatic pressBtn();
		@(posedge ref_clk);
		press <= 1'b1;
		@(posedge ref_clk);
		press <= 1'b0;
	endtask : pressBtn

	initial
	begin
		void'($urandom(52));
		for (int g = 0; g < 9; g++)
			gc[g] = 2'($urandom % 4);
		gw = 32'h0000_0000;
		for (int g = 0; g < 9; g++)
			gw[2 * g +: 2] = gc[g];
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		wb(0, 8'h00, 32'h0000_0000, 0, '1);
		wb(0, 8'h08, 32'hA987_6543, 0, '1);
		wb(0, 8'h0C, 32'h0000_0000, 0, '1);
		wb(0, 8'h14, 32'h0000_0000, 1, '1);
		wb(0, 8'h10, {29'h0, PRS_OFF}, 0, 32'h0000_0007);
		wb(1, 8'h0C, gw, 0, '1);
		wb(0, 8'h0C, gw, 0, '1);
		wb(1, 8'h08, 32'hA987_1110, 0, '1);
		wb(1, 8'h00, 32'h0000_0001, 0, '1);
		railQ.push_back('{8'h01, -1});
		wb(1, 8'h04, 32'h0000_0001, 0, '1);
		$display("test registers done");
		undervoltage_lockout <= 1'b1;
		pressBtn();
		repeat (30) @(posedge ref_clk);
		wb(0, 8'h10, {29'h0, PRS_OFF}, 0, 32'h0000_0007);
		undervoltage_lockout <= 1'b0;
		pushSeq(1);
		pressBtn();
		repeat (10) @(posedge ref_clk);
		wb(0, 8'h04, 32'h0000_0000, 1, '1);
		wb(1, 8'h04, 32'h0000_0000, 1, '1);
		waitFor(PRS_WAIT_EN, 5);
		repeat (100) @(posedge ref_clk);
		wb(0, 8'h04, 32'h0000_00FF, 0, '1);
		$display("test power-up done");
		hostEn <= 1'b1;
		waitFor(PRS_ACTIVE, 20);
		pushSeq(0);
		hostEn <= 1'b0;
		waitFor(PRS_PDOWN, 20);
		waitFor(PRS_SUSPEND, 500 * CPM + 20);
		check("discharge", 32'h0000_00FE, {24'h0, dischg});
		$display("test power-down done");
		pushSeq(1);
		pressBtn();
		waitFor(PRS_WAIT_EN, 20);
		pushSeq(0);
		waitFor(PRS_PDOWN, 20000 * CPM + 100);
		check("wait length", 1, n >= 20000 * CPM - 6
			&& n <= 20000 * CPM + 2);
		// Adapter falls during power-down, where it is ignored
		adapter <= 1'b1;
		waitFor(PRS_OFF, 500 * CPM + 20);
		check("notes left", 0, railQ.size());
		$display("test wait time-out done");
		pushSeq(1);
		bias <= 1'b1;
		waitFor(PRS_WAIT_EN, 20);
		repeat (150) @(posedge ref_clk);
		check("bias notes left", 0, railQ.size());
		$display("test bias wake done");
		complete_run();
	end
endmodule : test_power_rail_wakeup_sequencer

`default_nettype wire
